// File: include/afq_pkg.sv
// Purpose: Constants and types for the alert fault queue block
// Assumes: 8-bit register space, one clock
// Notes:   Reset values are plain defaults
package afq_pkg;
  // -------------------------------------------------
  // Register offsets
  // -------------------------------------------------
  localparam logic [7:0] ADR_CFG1   = 8'h01;
  localparam logic [7:0] ADR_CFG4   = 8'h04;
  localparam logic [7:0] ADR_FQ     = 8'h06;
  localparam logic [7:0] ADR_MASK1  = 8'h08;
  localparam logic [7:0] ADR_MASK2  = 8'h09;
  localparam logic [7:0] ADR_MASK3  = 8'h0a;
  localparam logic [7:0] ADR_RATE   = 8'h22;
  localparam logic [7:0] ADR_STAT1  = 8'h4f;
  localparam logic [7:0] ADR_STAT2  = 8'h50;
  localparam logic [7:0] ADR_STAT3  = 8'h51;
  // -------------------------------------------------
  // Field positions and masks
  // -------------------------------------------------
  localparam int         CFG1_MODE  = 3;
  localparam int         CFG4_REUSE = 7;
  localparam int         ST3_ALERT  = 0;
  localparam logic [7:0] MASK2_USED = 8'h1c;
  localparam logic [7:0] MASK3_USED = 8'he0;
  localparam logic [7:0] LVL2_USED  = 8'h18;
  // -------------------------------------------------
  // Reset values and rate codes
  // -------------------------------------------------
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_FQ     = 8'h00;
  localparam logic [7:0] RST_RATE   = 8'h07;
  localparam logic [7:0] RATE_MAX   = 8'h0a;
  localparam logic [7:0] RATE_NOAVG = 8'h08;
  localparam logic [2:0] Q_SAT      = 3'h4;
  // -------------------------------------------------
  // Types
  // -------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [7:0] value;
    logic [7:0] high_lim;
    logic [7:0] low_lim;
    logic       diode_err;
  } afq_meas_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afq_req_t;
endpackage : afq_pkg

// File: verilog/afq_ctrl.sv
// Purpose: Alert output, masks, fault queue and rate select
// Assumes: Sources and register port on the same clock
// Notes:   Alert and fault pins are open drain
`timescale 1ns/1ps
// Operation
// - Out-of-limit unmasked source pulls alert low
// - Config 1 bit 3 picks latched or level
// - Latched: status set, alert if unmasked
// - Latched alert held until read or ARA
// - Level mode alert follows live conditions
// - Mask blocks alert only, status still set
// - Temperature mask bit layout
// - Overtemp mask bits 4:2, rest reserved
// - Pin state never alerts in level mode
// - Fan mask bits 7:5, rest reserved
// - Fault pin shows status 3 bit 7 and 5 stalls unless reused
// - Queue only temperature, only latched mode
// - Per channel queue of consecutive faults
// - Queue counting ignores status bits
// - Queue depth priority decode
// - Queue reset by ARA, status 1 read
// - Queue reset releases alert
// - Rate codes 0 to 0x0a, rest reserved
// - No averaging at 16, 32, 64 per second
// - New rate waits for loop end
// - Sticky status cleared by read when gone
// - High is at-or-above, low strictly below
module afq_ctrl
  import afq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire afq_req_t   reg_req,
  output logic [7:0]      reg_rdata,
  input  wire afq_meas_t  meas,
  input  wire logic [2:0] ot_live,
  input  wire logic [2:0] fan_live,
  input  wire logic       loop_done,
  input  wire logic       ara_req,
  output logic            ara_ack,
  output logic            alert_pin,
  output logic            alert_oe,
  output logic            fault_pin,
  output logic            fault_oe,
  output logic [7:0]      rate_code,
  output logic            avg_en
);
  // -------------------------------------------------
  // Functions
  // -------------------------------------------------
  function automatic logic [2:0] q_depth(
    input logic [3:0] c);
    if (c[3])      q_depth = 3'h4;
    else if (c[2]) q_depth = 3'h3;
    else if (c[1]) q_depth = 3'h2;
    else           q_depth = 3'h1;
  endfunction : q_depth

  function automatic logic [7:0] ch_bits(
    input logic [1:0] ch, input logic h,
    input logic l, input logic d);
    case (ch)
      2'h0:    ch_bits = {h, l, 6'h00};
      2'h1:    ch_bits = {2'h0, h, l, d, 3'h0};
      2'h2:    ch_bits = {5'h00, h, l, d};
      default: ch_bits = 8'h00;
    endcase
  endfunction : ch_bits

  // -------------------------------------------------
  // Registers
  // -------------------------------------------------
  logic [7:0] cfg1_ff, cfg4_ff, fq_ff;
  logic [7:0] mask1_ff, mask2_ff, mask3_ff;
  logic [7:0] rate_pend_ff, rate_ff;
  logic [7:0] live1_ff, st1_ff, st2_ff, st3_ff;
  logic [7:0] fire_ff, rdata_ff;
  logic       alert_ff;
  logic [2:0] cnt_ff [3];

  // -------------------------------------------------
  // Decode
  // -------------------------------------------------
  wire       latched = ~cfg1_ff[CFG1_MODE];
  wire       wr      = reg_req.wr;
  wire       rd      = reg_req.rd;
  wire [7:0] ad      = reg_req.addr;
  wire       rd_st1  = rd && ad == ADR_STAT1;
  wire       rd_st2  = rd && ad == ADR_STAT2;
  wire       rd_st3  = rd && ad == ADR_STAT3;
  wire       ara_ok  = ara_req && alert_ff;
  wire       q_rst   = ara_ok || rd_st1;
  wire [2:0] depth   = q_depth(fq_ff[3:0]);

  // -------------------------------------------------
  // Limit compare
  // -------------------------------------------------
  wire       m_hi  = meas.value >= meas.high_lim;
  wire       m_lo  = meas.value < meas.low_lim;
  wire [7:0] m_out = meas.valid ?
    ch_bits(meas.chan, m_hi, m_lo, meas.diode_err) : 8'h00;
  wire [7:0] m_own = meas.valid ?
    ch_bits(meas.chan, 1'b1, 1'b1, 1'b1) : 8'h00;
  wire [7:0] nxt_live1 = (live1_ff & ~m_own) | m_out;
  wire [7:0] live2 = {3'h0, ot_live, 2'h0};
  wire [7:0] live3 = {fan_live, 5'h00};

  // -------------------------------------------------
  // Fault queues
  // -------------------------------------------------
  logic [7:0] fire_set;
  logic [2:0] nxt_cnt [3];
  for (genvar g = 0; g < 3; g++) begin : g_q
    wire       hit  = meas.valid && meas.chan == 2'(g);
    wire [2:0] base = q_rst ? 3'h0 : cnt_ff[g];
    wire [2:0] inc  = (base == Q_SAT) ? base : base + 3'h1;
    wire       bad  = |m_out;
    // Count ignores status and mask
    assign nxt_cnt[g] = !hit ? base : (bad ? inc : 3'h0);
  end
  wire [1:0] mc   = meas.chan;
  wire       full = (meas.chan < 2'h3) &&
                    (g_q[0].inc >= depth && mc == 2'h0 ||
                     g_q[1].inc >= depth && mc == 2'h1 ||
                     g_q[2].inc >= depth && mc == 2'h2);
  // Queue only in latched mode
  assign fire_set = (latched && full) ? m_out : 8'h00;
  // Reset releases, refill reasserts
  wire [7:0] nxt_fire = (fire_ff & ~{8{q_rst}}) | fire_set;

  // -------------------------------------------------
  // Sticky status, set wins over clear
  // -------------------------------------------------
  wire [7:0] clr1 = {8{rd_st1 | ara_ok}} & ~nxt_live1;
  wire [7:0] clr2 = {8{rd_st2 | ara_ok}} & ~live2;
  wire [7:0] clr3 = {8{rd_st3 | ara_ok}} & ~live3;
  // Mask does not gate status
  wire [7:0] nxt_st1 = (st1_ff & ~clr1) | m_out;
  wire [7:0] nxt_st2 = (st2_ff & ~clr2) | live2;
  wire [7:0] nxt_st3 = (st3_ff & ~clr3) | live3;

  // -------------------------------------------------
  // Alert sources
  // -------------------------------------------------
  wire [7:0] um2 = ~mask2_ff & MASK2_USED;
  wire [7:0] um3 = ~mask3_ff & MASK3_USED;
  wire src_lat = |(nxt_fire & ~mask1_ff) |
                 |(nxt_st2 & um2) |
                 |(nxt_st3 & um3);
  // Pin state excluded in level mode
  wire src_lvl = |(nxt_live1 & ~mask1_ff) |
                 |(live2 & um2 & LVL2_USED) |
                 |(live3 & um3);
  wire nxt_alert = latched ? src_lat : src_lvl;

  // -------------------------------------------------
  // Read mux
  // -------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    unique case (ad)
      ADR_CFG1:  rmux = cfg1_ff;
      ADR_CFG4:  rmux = cfg4_ff;
      ADR_FQ:    rmux = fq_ff;
      ADR_MASK1: rmux = mask1_ff;
      ADR_MASK2: rmux = mask2_ff;
      ADR_MASK3: rmux = mask3_ff;
      ADR_RATE:  rmux = rate_pend_ff;
      ADR_STAT1: rmux = st1_ff;
      ADR_STAT2: rmux = st2_ff;
      ADR_STAT3: rmux = st3_ff | {7'h00, alert_ff};
      default:   rmux = 8'h00;
    endcase
  end
  wire rate_ok = reg_req.wdata <= RATE_MAX;

  // -------------------------------------------------
  // Config write
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_ff      <= RST_CFG;
      cfg4_ff      <= RST_CFG;
      fq_ff        <= RST_FQ;
      mask1_ff     <= RST_MASK;
      mask2_ff     <= RST_MASK;
      mask3_ff     <= RST_MASK;
      rate_pend_ff <= RST_RATE;
    end else if (wr) begin
      if (ad == ADR_CFG1)  cfg1_ff  <= reg_req.wdata;
      if (ad == ADR_CFG4)  cfg4_ff  <= reg_req.wdata;
      if (ad == ADR_FQ)    fq_ff    <= reg_req.wdata;
      if (ad == ADR_MASK1) mask1_ff <= reg_req.wdata;
      if (ad == ADR_MASK2)
        mask2_ff <= reg_req.wdata & MASK2_USED;
      if (ad == ADR_MASK3)
        mask3_ff <= reg_req.wdata & MASK3_USED;
      if (ad == ADR_RATE && rate_ok)
        rate_pend_ff <= reg_req.wdata;
    end
  end

  // -------------------------------------------------
  // Rate apply at loop end
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)         rate_ff <= RST_RATE;
    else if (loop_done) rate_ff <= rate_pend_ff;
  end

  // -------------------------------------------------
  // State
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      live1_ff <= 8'h00;
      st1_ff   <= 8'h00;
      st2_ff   <= 8'h00;
      st3_ff   <= 8'h00;
      fire_ff  <= 8'h00;
      alert_ff <= 1'b0;
      rdata_ff <= 8'h00;
      for (int i = 0; i < 3; i++) cnt_ff[i] <= 3'h0;
    end else begin
      live1_ff <= nxt_live1;
      st1_ff   <= nxt_st1;
      st2_ff   <= nxt_st2;
      st3_ff   <= nxt_st3;
      fire_ff  <= nxt_fire;
      alert_ff <= nxt_alert;
      if (rd) rdata_ff <= rmux;
      for (int i = 0; i < 3; i++) cnt_ff[i] <= nxt_cnt[i];
    end
  end

  // -------------------------------------------------
  // Outputs
  // -------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign ara_ack   = ara_ok;
  assign alert_pin = 1'b0;
  assign alert_oe  = alert_ff;
  assign fault_pin = 1'b0;
  assign fault_oe  = ~cfg4_ff[CFG4_REUSE] &
                     (st3_ff[7] | st3_ff[5]);
  assign rate_code = rate_ff;
  assign avg_en    = rate_ff < RATE_NOAVG;

  // -------------------------------------------------
  // Assertions
  // -------------------------------------------------
  property p_status_set;
    @(posedge clk) disable iff (!rst_b)
      meas.valid && |m_out |=> (st1_ff & $past(m_out)) == $past(m_out);
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("Status bit not set");

  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
      |st1_ff && !rd_st1 && !ara_req |=>
        (st1_ff & $past(st1_ff)) == $past(st1_ff);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Status bit dropped");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      latched && alert_ff && !rd && !wr && !ara_req
        |=> alert_ff;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Latched alert released");

  property p_level;
    @(posedge clk) disable iff (!rst_b)
      !latched && !src_lvl && !wr |=> !alert_oe;
  endproperty
  a_level: assert property (p_level)
    else $error("Level alert not released");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
      q_rst && !meas.valid |=> fire_ff == 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("Queue not reset");

  property p_depth1;
    @(posedge clk) disable iff (!rst_b)
      latched && fq_ff[3:1] == 3'h0 && |m_out
        |=> |fire_ff;
  endproperty
  a_depth1: assert property (p_depth1)
    else $error("Depth one did not fire");

  property p_reuse;
    @(posedge clk) disable iff (!rst_b)
      cfg4_ff[CFG4_REUSE] |-> !fault_oe;
  endproperty
  a_reuse: assert property (p_reuse)
    else $error("Fault pin driven when reused");

  property p_defer;
    @(posedge clk) disable iff (!rst_b)
      !loop_done |=> $stable(rate_ff);
  endproperty
  a_defer: assert property (p_defer)
    else $error("Rate changed mid loop");

  property p_ara;
    @(posedge clk) disable iff (!rst_b)
      ara_req && !alert_oe |-> !ara_ack;
  endproperty
  a_ara: assert property (p_ara)
    else $error("ARA answered without alert");

  c_latch: cover property (@(posedge clk)
    latched && !alert_ff ##1 alert_ff);
  c_level: cover property (@(posedge clk)
    !latched && alert_ff ##1 !alert_ff);
  c_ara: cover property (@(posedge clk) ara_ack);
endmodule : afq_ctrl

// File: dv/afq_host_model.sv
// Purpose: Host side model for registers and alert response
// Assumes: Requests change 10 ns after the rising edge
// Notes:   Strobes last one cycle, bus shows inverse when idle
`timescale 1ns/1ps
module afq_host_model
  import afq_pkg::*;
(
  input  wire logic       clk,
  output afq_req_t        reg_req,
  input  wire logic [7:0] reg_rdata,
  output logic            ara_req,
  input  wire logic       ara_ack
);
  initial begin
    reg_req = '0;
    ara_req = 1'b0;
  end
  // -------------------------------------------------
  // Bus cycles
  // -------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    #10;
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #10;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask : rd
  // Alert response read, answer taken just before the edge
  task automatic ara(output logic ack);
    @(posedge clk);
    #10;
    ara_req = 1'b1;
    #80;
    ack = ara_ack;
    @(posedge clk);
    #10;
    ara_req = 1'b0;
  endtask : ara
  // Find source, then mask it while serviced
  task automatic handle(output logic [7:0] st);
    rd(ADR_STAT1, st);
    wr(ADR_MASK1, st);
  endtask : handle
endmodule : afq_host_model

// File: dv/afq_ctrl_tb.sv
// Purpose: Self-checking bench for the alert fault queue block
// Assumes: 10 MHz clock, inputs driven 10 ns after the edge
// Notes:   Host model supplies register and alert response cycles
`timescale 1ns/1ps
module afq_ctrl_tb;
  import afq_pkg::*;
  logic       clk;
  logic       rst_b;
  afq_meas_t  meas;
  logic [2:0] ot_live;
  logic [2:0] fan_live;
  logic       loop_done;
  afq_req_t   reg_req;
  logic [7:0] reg_rdata;
  logic       ara_req;
  logic       ara_ack;
  logic       alert_pin;
  logic       alert_oe;
  logic       fault_pin;
  logic       fault_oe;
  logic [7:0] rate_code;
  logic       avg_en;
  int         fail_count;
  int         n_compared;
  logic [7:0] st;
  logic       ack;
  afq_ctrl DUT (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .meas(meas), .ot_live(ot_live),
    .fan_live(fan_live), .loop_done(loop_done), .ara_req(ara_req),
    .ara_ack(ara_ack), .alert_pin(alert_pin), .alert_oe(alert_oe),
    .fault_pin(fault_pin), .fault_oe(fault_oe), .rate_code(rate_code),
    .avg_en(avg_en));
  afq_host_model host (.clk(clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ara_req(ara_req), .ara_ack(ara_ack));
  // -------------------------------------------------
  // Helpers
  // -------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdc
  task automatic send(input logic [1:0] ch, input logic [7:0] v);
    tick(1);
    meas = '{valid: 1'b1, chan: ch, value: v, high_lim: 8'h80,
             low_lim: 8'h20, diode_err: 1'b0};
    tick(1);
    meas = '{valid: 1'b0, chan: ~ch, value: ~v, high_lim: 8'h80,
             low_lim: 8'h20, diode_err: 1'b0};
    tick(1);
  endtask : send
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // -------------------------------------------------
  // Scenarios
  // -------------------------------------------------
  task automatic t_reset;
    chk({7'h0, alert_oe}, 8'h00);
    chk(rate_code, RST_RATE);
    chk({7'h0, avg_en}, 8'h01);
    rdc(ADR_MASK1, RST_MASK);
    rdc(ADR_FQ, RST_FQ);
    rdc(ADR_RATE, RST_RATE);
    rdc(ADR_CFG1, RST_CFG);
    rdc(ADR_CFG4, RST_CFG);
  endtask : t_reset
  task automatic t_latched;
    send(2'd0, 8'h80);
    chk({7'h0, alert_oe}, 8'h01);
    send(2'd0, 8'h50);
    chk({7'h0, alert_oe}, 8'h01);
    host.handle(st);
    chk(st, 8'h80);
    chk({7'h0, alert_oe}, 8'h00);
    rdc(ADR_STAT1, 8'h00);
    host.wr(ADR_MASK1, 8'h00);
  endtask : t_latched
  task automatic t_mask;
    host.wr(ADR_MASK1, 8'h20);
    send(2'd1, 8'hff);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd1, 8'h20);
    rdc(ADR_STAT1, 8'h20);
    send(2'd1, 8'h1f);
    chk({7'h0, alert_oe}, 8'h01);
    rdc(ADR_STAT1, 8'h10);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd1, 8'h50);
    rdc(ADR_STAT1, 8'h10);
    host.wr(ADR_MASK1, 8'h00);
  endtask : t_mask
  task automatic t_queue;
    host.wr(ADR_FQ, 8'h03);
    send(2'd2, 8'hff);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd2, 8'h50);
    send(2'd2, 8'hff);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd2, 8'hff);
    chk({7'h0, alert_oe}, 8'h01);
    host.ara(ack);
    chk({7'h0, ack}, 8'h01);
    tick(1);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd2, 8'hff);
    chk({7'h0, alert_oe}, 8'h00);
    send(2'd2, 8'hff);
    chk({7'h0, alert_oe}, 8'h01);
    host.ara(ack);
    send(2'd2, 8'h50);
    host.ara(ack);
    chk({7'h0, ack}, 8'h00);
    rdc(ADR_STAT1, 8'h04);
    rdc(ADR_STAT1, 8'h00);
  endtask : t_queue
  task automatic t_level;
    host.wr(ADR_CFG1, 8'h08);
    send(2'd0, 8'h10);
    chk({7'h0, alert_oe}, 8'h01);
    send(2'd0, 8'h50);
    chk({7'h0, alert_oe}, 8'h00);
    ot_live = 3'b001;
    tick(2);
    chk({7'h0, alert_oe}, 8'h00);
    ot_live = 3'b010;
    tick(2);
    chk({7'h0, alert_oe}, 8'h01);
    ot_live = 3'b000;
    tick(2);
    chk({7'h0, alert_oe}, 8'h00);
    rdc(ADR_STAT2, 8'h0c);
    rdc(ADR_STAT2, 8'h00);
  endtask : t_level
  task automatic t_fan;
    fan_live = 3'b100;
    tick(2);
    chk({7'h0, fault_oe}, 8'h01);
    rdc(ADR_STAT3, 8'h81);
    host.wr(ADR_MASK3, 8'hff);
    rdc(ADR_MASK3, 8'he0);
    chk({7'h0, alert_oe}, 8'h00);
    host.wr(ADR_MASK2, 8'hff);
    rdc(ADR_MASK2, 8'h1c);
    host.wr(ADR_CFG4, 8'h80);
    tick(1);
    chk({7'h0, fault_oe}, 8'h00);
    chk({6'h0, alert_pin, fault_pin}, 8'h00);
    fan_live = 3'b000;
    rdc(ADR_STAT3, 8'h80);
    rdc(ADR_STAT3, 8'h00);
  endtask : t_fan
  task automatic t_rate;
    logic [7:0] prev;
    prev = RST_RATE;
    for (int c = 0; c < 12; c++) begin
      host.wr(ADR_RATE, 8'(c));
      chk(rate_code, prev);
      loop_done = 1'b1;
      tick(1);
      loop_done = 1'b0;
      tick(1);
      if (c <= 10) begin
        prev = 8'(c);
      end
      chk(rate_code, prev);
      chk({7'h0, avg_en}, {7'h0, prev < 8'h08});
    end
  endtask : t_rate
  // -------------------------------------------------
  // Clock, reset, sequence and watchdog
  // -------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 5000);
    fail_count++;
    final_report();
  end
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_b = 1'b0;
    meas = '0;
    ot_live = 3'b000;
    fan_live = 3'b000;
    loop_done = 1'b0;
    repeat (20) @(posedge clk);
    #10;
    rst_b = 1'b1;
    t_reset();
    t_latched();
    t_mask();
    t_queue();
    t_level();
    t_fan();
    t_rate();
    final_report();
  end
endmodule : afq_ctrl_tb
